// [rtl/nrs_pkg.sv]
/*
 Constants of the non-overlap, loop tuning and rail order block.
 Assumes a command port from the management bus front end.
// What this block does
// [R1] Upper gap byte is high-to-low gap, signed nanoseconds
// [R2] Lower gap byte is low-to-high gap, signed nanoseconds
// [R3] Positive gap separates drive on-times, negative makes them overlap
// [R4] Frozen mode uses written gaps, clamped between floor and ceiling
// [R5] Leaving adaptive mode holds the last gap in use
// [R6] Host keeps written gaps within minus 15 to plus 60 ns
// [R7] Mode bit 15 picks adaptive or frozen high-to-low gap
// [R8] Mode bits 14:8 set high-to-low floor in 2 ns steps
// [R9] Mode bit 7 picks adaptive or frozen low-to-high gap
// [R10] Mode bits 6:0 set low-to-high floor in 2 ns steps
// [R11] Loop gain and residual follow measured input and output voltage
// [R12] Loop word: enable bit 24, residual 23:16, gain 15:0
// [R13] Loop word resets to gain 256, residual 90, enabled
// [R14] With prequel, output enables after own enable and prequel power-good
// [R15] With sequel, output shuts down after sequel power-down event
// [R16] Rail word bit 15 enables prequel, bits 12:8 its rail id
// [R17] Rail word bit 7 enables sequel, bits 4:0 its rail id
// [R18] Written rail word overrides the strap sequencing choice
// [R19] Unused bits read zero and do nothing
*/
package nrs_pkg;
  localparam logic [7:0] CMD_GAP = 8'hdd;
  localparam logic [7:0] CMD_MODE = 8'hde;
  localparam logic [7:0] CMD_LOOP = 8'hdf;
  localparam logic [7:0] CMD_RAIL = 8'he0;
  localparam logic [15:0] GAP_RESET = 16'h1010;
  localparam logic [15:0] MODE_RESET = 16'h0808;
  localparam logic [31:0] LOOP_RESET = 32'h015a0100;
  localparam logic [15:0] RAIL_RESET = 16'h0000;
  localparam logic [15:0] MODE_MASK = 16'hffff;
  localparam logic [31:0] LOOP_MASK = 32'h01ffffff;
  localparam logic [15:0] RAIL_MASK = 16'h9f9f;
  localparam int HL_LSB = 8;
  localparam int LH_LSB = 0;
  localparam int HL_FRZ = 15;
  localparam int LH_FRZ = 7;
  localparam int FLOOR_W = 7;
  localparam int LOOP_EN = 24;
  localparam int RES_LSB = 16;
  localparam int RES_W = 8;
  localparam int GAIN_W = 16;
  localparam int PRE_EN = 15;
  localparam int PRE_LSB = 8;
  localparam int SEQ_EN = 7;
  localparam int SEQ_LSB = 0;
  localparam int ID_W = 5;
  localparam int FLOOR_STEP_NS = 2;
  localparam logic EV_POWER_GOOD = 1'b0;
  localparam logic EV_POWER_DOWN = 1'b1;
  typedef enum logic [1:0] {
    NRS_OFF, NRS_WAIT_PRE, NRS_ON, NRS_HELD_OFF
  } nrs_rail_t;
endpackage

// [rtl/nrs_config.sv]
/*
 Non-overlap gap control, charge loop tuning registers and rail order
 sequencing. Assumes a command port decoded from the management bus,
 event words decoded from the single wire inter-chip bus, and one clock.
*/
`timescale 1ns/100ps
`default_nettype none
module nrs_config (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [31:0] cmd_wdata,
  output logic [31:0] cmd_rdata,
  output logic cmd_rvalid,
  output logic cmd_nack,
  input wire logic signed [7:0] adapt_hl_gap,
  input wire logic signed [7:0] adapt_lh_gap,
  input wire logic signed [7:0] nonoverlap_ceiling_hl,
  input wire logic signed [7:0] nonoverlap_ceiling_lh,
  output logic signed [7:0] hs_to_ls_gap,
  output logic signed [7:0] ls_to_hs_gap,
  input wire logic tune_valid,
  input wire logic [15:0] vin_code,
  input wire logic [15:0] vout_code,
  output logic loop_enable,
  output logic [15:0] loop_gain,
  output logic [7:0] loop_residual,
  input wire logic strap_prequel_en,
  input wire logic [4:0] strap_prequel_id,
  input wire logic strap_sequel_en,
  input wire logic [4:0] strap_sequel_id,
  input wire logic on_request,
  input wire logic bus_event_valid,
  input wire logic bus_event_kind,
  input wire logic [4:0] bus_event_rail,
  output logic out_enable,
  output logic shutdown_start
);
  logic [15:0] gap_reg;
  logic [15:0] mode_reg;
  logic [31:0] loop_reg;
  logic [15:0] rail_reg;
  logic rail_written;
  logic strap_taken;
  logic [15:0] strap_word;
  logic signed [7:0] held_hl;
  logic signed [7:0] held_lh;
  logic prequel_good;
  nrs_pkg::nrs_rail_t state;
  nrs_pkg::nrs_rail_t next_state;
  logic wr_gap;
  logic wr_mode;
  logic wr_loop;
  logic wr_rail;
  logic [15:0] seq_word;
  logic pre_en;
  logic seq_en;
  logic [4:0] pre_id;
  logic [4:0] seq_id;
  logic signed [9:0] next_hl;
  logic signed [9:0] next_lh;
  logic [15:0] auto_gain;
  logic [7:0] auto_res;
  logic [31:0] read_word;
  logic read_hit;

  assign wr_gap = cmd_valid && cmd_write && cmd_code == nrs_pkg::CMD_GAP;
  assign wr_mode = cmd_valid && cmd_write && cmd_code == nrs_pkg::CMD_MODE;
  assign wr_loop = cmd_valid && cmd_write && cmd_code == nrs_pkg::CMD_LOOP;
  assign wr_rail = cmd_valid && cmd_write && cmd_code == nrs_pkg::CMD_RAIL;

  // Clamp a gap to floor (2 ns units) and ceiling
  function automatic logic signed [9:0] clamp_gap(
    input logic signed [7:0] want,
    input logic [6:0] floor_code,
    input logic signed [7:0] ceil_ns
  );
    logic signed [9:0] lo;
    logic signed [9:0] v;
    lo = $signed(10'(floor_code) * 10'(nrs_pkg::FLOOR_STEP_NS)); // see [R8] [R10]
    v = 10'(want);
    if (v < lo) begin
      v = lo;
    end
    if (v > 10'(ceil_ns)) begin
      v = 10'(ceil_ns);
    end
    return v;
  endfunction

  // Applied high-to-low gap: adaptive request or held value, then clamped
  always_comb begin
    next_hl = clamp_gap(mode_reg[nrs_pkg::HL_FRZ] ? held_hl : adapt_hl_gap,
      mode_reg[nrs_pkg::HL_LSB +: nrs_pkg::FLOOR_W],
      nonoverlap_ceiling_hl); // see [R4] [R7]
  end

  // Applied low-to-high gap, same rules
  always_comb begin
    next_lh = clamp_gap(mode_reg[nrs_pkg::LH_FRZ] ? held_lh : adapt_lh_gap,
      mode_reg[nrs_pkg::LH_LSB +: nrs_pkg::FLOOR_W],
      nonoverlap_ceiling_lh); // see [R4] [R9]
  end

  // High-to-low gap output, sign kept: negative means overlap
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      hs_to_ls_gap <= nrs_pkg::GAP_RESET[nrs_pkg::HL_LSB +: 8];
    end else begin
      hs_to_ls_gap <= next_hl[7:0]; // see [R1] [R3]
    end
  end

  // Low-to-high gap output, sign kept
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ls_to_hs_gap <= nrs_pkg::GAP_RESET[nrs_pkg::LH_LSB +: 8];
    end else begin
      ls_to_hs_gap <= next_lh[7:0]; // see [R2] [R3]
    end
  end

  // Written gap word; stored whole, host keeps it in range
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      gap_reg <= nrs_pkg::GAP_RESET;
    end else if (wr_gap) begin
      gap_reg <= cmd_wdata[15:0]; // see [R1] [R2] [R6]
    end
  end

  // Held high-to-low gap: a write loads it, a freeze captures the live gap
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      held_hl <= nrs_pkg::GAP_RESET[nrs_pkg::HL_LSB +: 8];
    end else if (wr_mode && cmd_wdata[nrs_pkg::HL_FRZ]
        && !mode_reg[nrs_pkg::HL_FRZ]) begin
      held_hl <= hs_to_ls_gap; // see [R5]
    end else if (wr_gap) begin
      held_hl <= cmd_wdata[nrs_pkg::HL_LSB +: 8]; // see [R4]
    end
  end

  // Held low-to-high gap, same rules
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      held_lh <= nrs_pkg::GAP_RESET[nrs_pkg::LH_LSB +: 8];
    end else if (wr_mode && cmd_wdata[nrs_pkg::LH_FRZ]
        && !mode_reg[nrs_pkg::LH_FRZ]) begin
      held_lh <= ls_to_hs_gap; // see [R5]
    end else if (wr_gap) begin
      held_lh <= cmd_wdata[nrs_pkg::LH_LSB +: 8]; // see [R4]
    end
  end

  // Mode and floor word
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      mode_reg <= nrs_pkg::MODE_RESET;
    end else if (wr_mode) begin
      mode_reg <= cmd_wdata[15:0] & nrs_pkg::MODE_MASK; // see [R7] [R9]
    end
  end

  // Suggested tuning from measured voltages: gain grows with the
  // conversion ratio, residual halves when output is under an eighth of input
  always_comb begin
    auto_gain = nrs_pkg::LOOP_RESET[15:0];
    auto_res = nrs_pkg::LOOP_RESET[nrs_pkg::RES_LSB +: nrs_pkg::RES_W];
    if (vout_code > (vin_code >> 1)) begin
      auto_gain = nrs_pkg::LOOP_RESET[15:0] << 1; // see [R11]
    end else if (vout_code < (vin_code >> 3)) begin
      auto_gain = nrs_pkg::LOOP_RESET[15:0] >> 1; // see [R11]
      auto_res = nrs_pkg::LOOP_RESET[nrs_pkg::RES_LSB +: nrs_pkg::RES_W] >> 1;
    end
  end

  // Loop word: host write wins over an automatic update
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      loop_reg <= nrs_pkg::LOOP_RESET; // see [R13]
    end else if (wr_loop) begin
      loop_reg <= cmd_wdata & nrs_pkg::LOOP_MASK; // see [R12] [R19]
    end else if (tune_valid) begin
      loop_reg[nrs_pkg::RES_LSB +: nrs_pkg::RES_W] <= auto_res; // see [R11]
      loop_reg[0 +: nrs_pkg::GAIN_W] <= auto_gain; // see [R11]
    end
  end

  assign loop_enable = loop_reg[nrs_pkg::LOOP_EN]; // see [R12]
  assign loop_residual = loop_reg[nrs_pkg::RES_LSB +: nrs_pkg::RES_W];
  assign loop_gain = loop_reg[0 +: nrs_pkg::GAIN_W];

  // Rail order word
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rail_reg <= nrs_pkg::RAIL_RESET;
    end else if (wr_rail) begin
      rail_reg <= cmd_wdata[15:0] & nrs_pkg::RAIL_MASK; // see [R19]
    end
  end

  // Set by the first host write; the strap is ignored from then on
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rail_written <= 1'b0;
    end else if (wr_rail) begin
      rail_written <= 1'b1; // see [R18]
    end
  end

  // Strap caught once after reset release
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      strap_taken <= 1'b0;
    end else begin
      strap_taken <= 1'b1;
    end
  end

  // Strap word, frozen from the first edge after release
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      strap_word <= nrs_pkg::RAIL_RESET;
    end else if (!strap_taken) begin
      strap_word <= {strap_prequel_en, 2'b00, strap_prequel_id,
        strap_sequel_en, 2'b00, strap_sequel_id};
    end
  end

  assign seq_word = rail_written ? rail_reg : strap_word; // see [R18]
  assign pre_en = seq_word[nrs_pkg::PRE_EN]; // see [R16]
  assign pre_id = seq_word[nrs_pkg::PRE_LSB +: nrs_pkg::ID_W]; // see [R16]
  assign seq_en = seq_word[nrs_pkg::SEQ_EN]; // see [R17]
  assign seq_id = seq_word[nrs_pkg::SEQ_LSB +: nrs_pkg::ID_W]; // see [R17]

  // Prequel power state; power-good sets, power-down clears
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      prequel_good <= 1'b0;
    end else if (bus_event_valid && bus_event_rail == pre_id) begin
      prequel_good <= bus_event_kind == nrs_pkg::EV_POWER_GOOD; // see [R14]
    end
  end

  // Rail enable sequence
  always_comb begin
    next_state = state;
    unique case (state)
      nrs_pkg::NRS_OFF: begin
        if (on_request) begin
          next_state = nrs_pkg::NRS_WAIT_PRE;
        end
      end
      nrs_pkg::NRS_WAIT_PRE: begin
        if (!on_request) begin
          next_state = nrs_pkg::NRS_OFF;
        end else if (!pre_en || prequel_good) begin
          next_state = nrs_pkg::NRS_ON; // see [R14]
        end
      end
      nrs_pkg::NRS_ON: begin
        if (!on_request) begin
          next_state = nrs_pkg::NRS_OFF;
        end else if (seq_en && bus_event_valid && bus_event_rail == seq_id
            && bus_event_kind == nrs_pkg::EV_POWER_DOWN) begin
          next_state = nrs_pkg::NRS_HELD_OFF; // see [R15]
        end
      end
      nrs_pkg::NRS_HELD_OFF: begin
        if (!on_request) begin
          next_state = nrs_pkg::NRS_OFF;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state <= nrs_pkg::NRS_OFF;
    end else begin
      state <= next_state;
    end
  end

  // Enable level follows the sequence state
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      out_enable <= 1'b0;
    end else begin
      out_enable <= next_state == nrs_pkg::NRS_ON; // see [R14]
    end
  end

  // One-cycle start of the delayed shutdown
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      shutdown_start <= 1'b0;
    end else begin
      shutdown_start <= state == nrs_pkg::NRS_ON
        && next_state != nrs_pkg::NRS_ON; // see [R15]
    end
  end

  // Read word of the addressed command; unused bits already zero
  always_comb begin
    read_word = 32'h00000000;
    read_hit = 1'b1;
    unique case (cmd_code)
      nrs_pkg::CMD_GAP: read_word = {16'h0000, gap_reg};
      nrs_pkg::CMD_MODE: read_word = {16'h0000, mode_reg};
      nrs_pkg::CMD_LOOP: read_word = loop_reg; // see [R19]
      nrs_pkg::CMD_RAIL: read_word = {16'h0000, seq_word};
      default: begin
        read_hit = 1'b0;
      end
    endcase
  end

  // Read data holds until the next access
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cmd_rdata <= 32'h00000000;
    end else if (cmd_valid) begin
      cmd_rdata <= read_word;
    end
  end

  // Answer strobes stand one cycle after the access
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cmd_rvalid <= 1'b0;
      cmd_nack <= 1'b0;
    end else begin
      cmd_rvalid <= cmd_valid && !cmd_write && read_hit;
      cmd_nack <= cmd_valid && !read_hit;
    end
  end
endmodule // nrs_config
`default_nettype wire

// [testbench/nrs_config_props.sv]
/*
 Port checks for the gap, loop and rail order block.
 Assumes a bind onto nrs_config with one clock.
*/
`timescale 1ns/100ps
`default_nettype none
module nrs_config_props (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [31:0] cmd_rdata,
  input wire logic cmd_rvalid,
  input wire logic cmd_nack,
  input wire logic on_request,
  input wire logic out_enable,
  input wire logic shutdown_start
);
  logic mapped;
  assign mapped = cmd_code inside {nrs_pkg::CMD_GAP, nrs_pkg::CMD_MODE, nrs_pkg::CMD_LOOP,
    nrs_pkg::CMD_RAIL};
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  a_read_answer: assert property (
    cmd_valid && !cmd_write && mapped |=> cmd_rvalid && !cmd_nack)
    else $error("mapped read not answered");
  a_nack_unmapped: assert property (
    cmd_valid && !mapped |=> cmd_nack && !cmd_rvalid)
    else $error("unmapped access not refused");
  a_no_stray_ack: assert property (
    cmd_rvalid || cmd_nack |-> $past(cmd_valid))
    else $error("answer without access");
  a_loop_unused: assert property (
    cmd_rvalid && $past(cmd_code) == nrs_pkg::CMD_LOOP |-> cmd_rdata[31:25] == 7'h00)
    else $error("loop word unused bits set");
  a_rail_unused: assert property (
    cmd_rvalid && $past(cmd_code) == nrs_pkg::CMD_RAIL
    |-> cmd_rdata[31:16] == 16'h0000 && cmd_rdata[14:13] == 2'h0 && cmd_rdata[6:5] == 2'h0)
    else $error("rail word unused bits set");
  a_on_needs_req: assert property (
    $rose(out_enable) |-> $past(on_request))
    else $error("output on without request");
  a_drop_ends_on: assert property (
    out_enable && !on_request |=> !out_enable)
    else $error("output stays on after request drop");
  a_shut_pulse: assert property (
    shutdown_start |-> $fell(out_enable) ##1 !shutdown_start)
    else $error("shutdown pulse wrong");
endmodule // nrs_config_props
bind nrs_config nrs_config_props nrs_config_props_inst (.ref_clk(ref_clk), .reset(reset),
  .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_rdata(cmd_rdata),
  .cmd_rvalid(cmd_rvalid), .cmd_nack(cmd_nack), .on_request(on_request),
  .out_enable(out_enable), .shutdown_start(shutdown_start));
`default_nettype wire

// [testbench/nrs_peer.sv]
/*
 Peer controller on the inter-chip bus, sending one event per request.
 Assumes requests are raised for one cycle off the falling edge.
*/
`timescale 1ns/100ps
`default_nettype none
module nrs_peer (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic send,
  input wire logic send_kind,
  input wire logic [4:0] send_rail,
  output logic bus_event_valid,
  output logic bus_event_kind,
  output logic [4:0] bus_event_rail
);
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      bus_event_valid <= 1'b0;
      bus_event_kind <= 1'b0;
      bus_event_rail <= 5'h00;
    end else begin
      bus_event_valid <= send;
      // Idle fields toggle so stale values are never trusted
      bus_event_kind <= send ? send_kind : ~bus_event_kind;
      bus_event_rail <= send ? send_rail : ~bus_event_rail;
    end
  end
endmodule // nrs_peer
`default_nettype wire

// [testbench/nrs_config_tb.sv]
/*
 Self-checking bench for the gap, loop and rail order block.
 Assumes the design and peer model compiled before it.
*/
`timescale 1ns/100ps
`default_nettype none
module nrs_config_tb;
  logic ref_clk = 1'b0, reset = 1'b1, cmd_valid = 1'b0, cmd_write = 1'b0, tune_valid = 1'b0;
  logic [7:0] cmd_code = 8'h00;
  logic [31:0] cmd_wdata = 32'h0, cmd_rdata;
  logic cmd_rvalid, cmd_nack, loop_enable, out_enable, shutdown_start;
  logic signed [7:0] adapt_hl_gap = 8'sh14, adapt_lh_gap = 8'sh14;
  logic signed [7:0] nonoverlap_ceiling_hl = 8'sh3c, nonoverlap_ceiling_lh = 8'sh3c;
  logic signed [7:0] hs_to_ls_gap, ls_to_hs_gap;
  logic [15:0] vin_code = 16'h0064, vout_code = 16'h0050, loop_gain;
  logic [7:0] loop_residual;
  logic strap_prequel_en = 1'b1, strap_sequel_en = 1'b0, on_request = 1'b0;
  logic [4:0] strap_prequel_id = 5'h05, strap_sequel_id = 5'h00, bus_event_rail, ev_rail = 5'h0;
  logic bus_event_valid, bus_event_kind, ev_send = 1'b0, ev_kind = 1'b0;
  logic [1:0] ack;
  int fails = 0;
  int n_checks = 0;
  nrs_config nrs_config_inst (.ref_clk, .reset, .cmd_valid, .cmd_write, .cmd_code, .cmd_wdata,
    .cmd_rdata, .cmd_rvalid, .cmd_nack, .adapt_hl_gap, .adapt_lh_gap, .nonoverlap_ceiling_hl,
    .nonoverlap_ceiling_lh, .hs_to_ls_gap, .ls_to_hs_gap, .tune_valid, .vin_code, .vout_code,
    .loop_enable, .loop_gain, .loop_residual, .strap_prequel_en, .strap_prequel_id,
    .strap_sequel_en, .strap_sequel_id, .on_request, .bus_event_valid, .bus_event_kind,
    .bus_event_rail, .out_enable, .shutdown_start);
  nrs_peer nrs_peer_inst (.ref_clk, .reset, .send(ev_send), .send_kind(ev_kind),
    .send_rail(ev_rail), .bus_event_valid, .bus_event_kind, .bus_event_rail);
  always #20 ref_clk = ~ref_clk;
  task automatic close_out();
    if (fails == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic acc(input logic wr, input logic [7:0] code, input logic [31:0] d);
    @(negedge ref_clk);
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_code = code;
    cmd_wdata = d;
    @(negedge ref_clk);
    ack = {cmd_rvalid, cmd_nack};
    cmd_valid = 1'b0;
  endtask
  task automatic rd(input logic [7:0] code, input logic [31:0] exp);
    acc(1'b0, code, 32'h0);
    chk("read ack", 32'(2'b10), 32'(ack));
    chk("read data", exp, cmd_rdata);
  endtask
  task automatic gaps(input logic [7:0] hl, input logic [7:0] lh);
    repeat (3) @(negedge ref_clk);
    chk("hs_to_ls_gap", 32'(hl), 32'(hs_to_ls_gap));
    chk("ls_to_hs_gap", 32'(lh), 32'(ls_to_hs_gap));
  endtask
  task automatic wait_oe(input logic v);
    for (int i = 0; i < 20; i++) begin
      @(negedge ref_clk);
      if (out_enable === v) break;
    end
    chk("out_enable", 32'(v), 32'(out_enable));
    if (out_enable !== v) close_out();
  endtask
  task automatic ev(input logic k, input logic [4:0] r);
    @(negedge ref_clk);
    ev_send = 1'b1;
    ev_kind = k;
    ev_rail = r;
    @(negedge ref_clk);
    ev_send = 1'b0;
  endtask
  task automatic t_reset();
    rd(8'hdd, 32'h1010);
    rd(8'hde, 32'h0808);
    rd(8'hdf, 32'h015a0100);
    rd(8'he0, 32'h8500);
  endtask
  task automatic t_unused();
    acc(1'b1, 8'hdf, 32'hffffffff);
    rd(8'hdf, 32'h01ffffff);
    acc(1'b1, 8'he0, 32'h0000ffff);
    rd(8'he0, 32'h9f9f);
    acc(1'b0, 8'he1, 32'h0);
    chk("unmapped ack", 32'(2'b01), 32'(ack));
  endtask
  task automatic t_frozen();
    acc(1'b1, 8'hde, 32'h8387);
    acc(1'b1, 8'hdd, 32'h0a14);
    gaps(8'h0a, 8'h14);
    nonoverlap_ceiling_lh = 8'sh10;
    acc(1'b1, 8'hde, 32'h8687);
    gaps(8'h0c, 8'h10);
    nonoverlap_ceiling_lh = 8'sh3c;
  endtask
  task automatic t_adapt();
    acc(1'b1, 8'hde, 32'h0000);
    adapt_lh_gap = 8'sh1e;
    gaps(8'h14, 8'h1e);
    acc(1'b1, 8'hde, 32'h8080);
    adapt_hl_gap = 8'sh28;
    adapt_lh_gap = 8'sh28;
    gaps(8'h14, 8'h1e);
  endtask
  task automatic t_loop();
    acc(1'b1, 8'hdf, 32'h00200300);
    chk("loop word", 32'h00200300, {7'h0, loop_enable, loop_residual, loop_gain});
    for (int i = 0; i < 2; i++) begin
      @(negedge ref_clk);
      vout_code = (i == 0) ? 16'h0050 : 16'h000a;
      tune_valid = 1'b1;
      @(negedge ref_clk);
      tune_valid = 1'b0;
      @(negedge ref_clk);
      chk("loop_gain", (i == 0) ? 32'h200 : 32'h80, 32'(loop_gain));
    end
    chk("loop_residual", 32'h2d, 32'(loop_residual));
  endtask
  task automatic t_seq();
    acc(1'b1, 8'he0, 32'h0000);
    on_request = 1'b1;
    wait_oe(1'b1);
    on_request = 1'b0;
    wait_oe(1'b0);
    chk("shutdown_start", 32'h1, 32'(shutdown_start));
    acc(1'b1, 8'he0, 32'h8581);
    on_request = 1'b1;
    ev(1'b0, 5'h04);
    repeat (4) @(negedge ref_clk);
    chk("out_enable held", 32'h0, 32'(out_enable));
    ev(1'b0, 5'h05);
    wait_oe(1'b1);
    ev(1'b1, 5'h01);
    wait_oe(1'b0);
    chk("shutdown_start", 32'h1, 32'(shutdown_start));
    on_request = 1'b0;
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    reset = 1'b0;
    repeat (2) @(negedge ref_clk);
    t_reset();
    t_unused();
    t_frozen();
    t_adapt();
    t_loop();
    t_seq();
    close_out();
  end
endmodule // nrs_config_tb
`default_nettype wire
